// File: rtc_cfg.svh
/*
  rtc_cfg.svh: register offsets, field positions, reset values and
  timing figures of the reset timeout and cause block.
  Assumes a 50 MHz ref_clk and an APB bus with 32-bit data.
*/
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ********************************************************************
// register offsets (byte addresses)
// ********************************************************************
`define RTC_CTRL_OFS        8'h00
`define RTC_CAUSE_OFS       8'h04
`define RTC_STACK_OFS       8'h08
`define RTC_STATE_OFS       8'h0C

// ********************************************************************
// field positions
// ********************************************************************
`define RTC_CAUSE_SOFT_BIT   6
`define RTC_CAUSE_RINST_BIT  4
`define RTC_CAUSE_TO_BIT     3
`define RTC_CAUSE_PDOWN_BIT  2
`define RTC_CAUSE_POR_BIT    1
`define RTC_CAUSE_DIP_BIT    0
`define RTC_STK_FULL_BIT     7
`define RTC_STK_UNF_BIT      6
`define RTC_STATE_RUN_BIT    4
`define RTC_STATE_RST_BIT    5

// ********************************************************************
// reset values
// ********************************************************************
`define RTC_CTRL_RST        8'h00
`define RTC_CAUSE_RST       6'h1C
`define RTC_STACK_RST       2'h0
`define RTC_VEC_RESET       16'h0000
`define RTC_VEC_HIGH        16'h0008
`define RTC_VEC_LOW         16'h0018

// ********************************************************************
// timing
// ********************************************************************
`define RTC_CLK_HZ          50000000
`define RTC_SLOW_PERIOD_NS  32000
`define RTC_PUT_MS          66
`define RTC_PUT_TICKS       2048
`define RTC_XTAL_EDGES      1024
`define RTC_PLL_LOCK_US     2000

`endif

// File: rtc_pkg.sv
/*
  rtc_pkg: types of the reset timeout and cause block.
  Assumes rtc_cfg.svh holds all numeric constants.
*/
package rtc_pkg;

  typedef enum logic [3:0] {
    FAST_CRYSTAL_MODE              = 4'h0,
    STD_CRYSTAL_MODE               = 4'h1,
    FAST_CRYSTAL_MULTIPLIED_MODE   = 4'h2,
    STD_CRYSTAL_MULTIPLIED_MODE    = 4'h3,
    EXTERNAL_CLOCK_MODE            = 4'h4,
    EXT_CLOCK_GPIO_MODE            = 4'h5,
    EXT_CLOCK_MULTIPLIED_MODE      = 4'h6,
    EXT_CLOCK_MULTIPLIED_GPIO_MODE = 4'h7,
    INTERNAL_OSC_GPIO_MODE         = 4'h8,
    INTERNAL_OSC_CLKOUT_MODE       = 4'h9,
    INTERNAL_OSC_FAST_CRYSTAL_MODE = 4'hA,
    INTERNAL_OSC_STD_CRYSTAL_MODE  = 4'hB,
    RESISTOR_CAP_OSC_MODE          = 4'hC
  } rtc_osc_mode_t;

  typedef enum logic [1:0] {
    PM_FULL  = 2'b00,
    PM_RUN   = 2'b01,
    PM_IDLE  = 2'b10,
    PM_SLEEP = 2'b11
  } rtc_pm_t;

  typedef enum logic [2:0] {
    ST_BROWN = 3'b000,
    ST_START = 3'b001,
    ST_PUT   = 3'b010,
    ST_XTAL  = 3'b011,
    ST_PLL   = 3'b100,
    ST_PIN   = 3'b101,
    ST_RUN   = 3'b110
  } rtc_state_t;

  typedef struct packed {
    logic wdog_timeout;
    logic stack_full;
    logic stack_underflow;
    logic reset_instr;
    logic irq_wake;
    logic irq_is_high;
    logic high_priority_irq_enable;
    logic low_priority_irq_enable;
  } rtc_evt_t;

  typedef struct packed {
    logic soft_en;
    logic rinst;
    logic to;
    logic pdown;
    logic por;
    logic dip;
  } rtc_cause_t;

  typedef struct packed {
    logic          stk_rst_en;
    logic [1:0]    supply_cfg;
    logic          put_dis_n;
    rtc_osc_mode_t mode;
  } rtc_ctrl_t;

endpackage

// File: rtc_top.sv
/*
  rtc_top: reset sequencer and reset cause flags with an APB slave.
  Assumes events in evt and pm_mode come from core logic on ref_clk;
  pins and the supply detector are asynchronous and are synchronised.
  reset_n is the power-on pulse.
*/
// Local design decisions: the address map and the APB slave port.
// Operation
// - crystal timer counts 1024 oscillator pin edges
// - crystal delay only crystal modes, power/wake
// - multiplier lock wait follows crystal delay
// - power-up timer runs before crystal timer
// - rc mode, timer disabled: no delay
// - delays count from power pulse, pin separate
// - power-up timer only on power and supply dip
// - wake delay chosen by oscillator mode
// - registers kept on resets other than power
// - watchdog wake resumes normal operation
// - power-on flag values and address zero
// - supply dip and reset instruction flags
// - watchdog reset while running clears timeout
// - watchdog in idle/sleep wakes, clears two
// - pin reset in low power sets timeout
// - pin reset at full power keeps flags
// - stack error resets when enable set
// - underflow without enable only flags
// - interrupt wake clears power-down, vectors
// - soft supply monitor enable reset value
// - power-up timer enabled by zero bit
// - power-up timer 11 bits on slow tick
// - hardware never sets power-on flag
`timescale 1ns/10ps
`include "rtc_cfg.svh"

module rtc_top
  import rtc_pkg::*;
#(
  parameter int unsigned SLOW_DIV_CYC =
    (`RTC_SLOW_PERIOD_NS * (`RTC_CLK_HZ / 1000000)) / 1000,
  parameter int unsigned PLL_LOCK_CYC =
    `RTC_PLL_LOCK_US * (`RTC_CLK_HZ / 1000000)
)(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        external_reset_n_pin,
  input  wire logic        osc_input_pin,
  input  wire logic        brownout_det,
  input  wire rtc_pm_t     pm_mode,
  input  wire rtc_evt_t    evt,
  output wire logic        core_reset,
  output wire logic        core_run,
  output wire logic        pc_load,
  output wire logic        pc_resume,
  output wire logic [15:0] pc_value
);

  // ******************************************************************
  // synchronisers and edge detect
  // ******************************************************************
  logic [2:0]  sy1_q;
  logic [2:0]  sy2_q;
  logic        osc_prev_q;
  wire  [2:0]  pins = {brownout_det, osc_input_pin,
                       external_reset_n_pin};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_q      <= 3'h0;
      sy2_q      <= 3'h0;
      osc_prev_q <= 1'b0;
    end else begin
      sy1_q      <= pins;
      sy2_q      <= sy1_q;
      osc_prev_q <= sy2_q[1];
    end
  end

  wire pin_s     = sy2_q[0];
  wire brown_s   = sy2_q[2];
  wire osc_edge  = sy2_q[1] & ~osc_prev_q;

  // ******************************************************************
  // state
  // ******************************************************************
  rtc_state_t  st_q;
  rtc_state_t  st_d;
  rtc_ctrl_t   ctrl_q;
  rtc_cause_t  cause_q;
  rtc_cause_t  cause_d;
  logic [1:0]  stk_q;
  logic [1:0]  stk_d;
  logic [16:0] cnt_q;
  logic [11:0] div_q;
  logic        power_q;
  logic        power_d;
  logic        wake_q;
  logic        wake_d;
  logic        resume_q;
  logic        resume_d;
  logic [15:0] vec_q;
  logic [15:0] vec_d;
  logic        core_reset_q;
  logic        core_run_q;
  logic        pc_load_q;
  logic        pc_resume_q;
  logic [15:0] pc_value_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // ******************************************************************
  // mode decode
  // ******************************************************************
  wire rtc_osc_mode_t mode = ctrl_q.mode;
  wire is_xtal = (mode == FAST_CRYSTAL_MODE) ||
                 (mode == STD_CRYSTAL_MODE) ||
                 (mode == FAST_CRYSTAL_MULTIPLIED_MODE) ||
                 (mode == STD_CRYSTAL_MULTIPLIED_MODE) ||
                 (mode == INTERNAL_OSC_FAST_CRYSTAL_MODE) ||
                 (mode == INTERNAL_OSC_STD_CRYSTAL_MODE);
  wire is_pll  = (mode == FAST_CRYSTAL_MULTIPLIED_MODE) ||
                 (mode == STD_CRYSTAL_MULTIPLIED_MODE) ||
                 (mode == EXT_CLOCK_MULTIPLIED_MODE) ||
                 (mode == EXT_CLOCK_MULTIPLIED_GPIO_MODE);
  // active-low enable bit; only power-up and supply dip use it
  wire put_use  = power_q & ~ctrl_q.put_dis_n;
  wire need_dly = power_q | wake_q;
  // rc and plain clock modes fall through to the pin wait
  wire rtc_state_t after_put =
    (is_xtal & need_dly) ? ST_XTAL :
    (is_pll & need_dly)  ? ST_PLL : ST_PIN;

  wire soft_cfg = (ctrl_q.supply_cfg == 2'b01);
  wire dip_on   = (ctrl_q.supply_cfg == 2'b11) ||
                  ((ctrl_q.supply_cfg == 2'b10) &&
                   (pm_mode != PM_SLEEP)) ||
                  (soft_cfg && cause_q.soft_en);

  // ******************************************************************
  // events, highest priority first
  // ******************************************************************
  wire in_run    = (st_q == ST_RUN);
  wire sleepy    = (pm_mode == PM_IDLE) || (pm_mode == PM_SLEEP);
  wire e_brown   = dip_on & brown_s & (st_q != ST_BROWN);
  wire e_pin     = in_run & ~pin_s & ~e_brown;
  wire free      = in_run & pin_s & ~e_brown;
  wire e_full    = free & evt.stack_full & ctrl_q.stk_rst_en;
  wire e_unf     = free & evt.stack_underflow;
  wire e_stk_rst = e_full | (e_unf & ctrl_q.stk_rst_en);
  wire e_wd_rst  = free & evt.wdog_timeout & ~sleepy & ~e_stk_rst;
  wire e_rinst   = free & evt.reset_instr & ~e_stk_rst & ~e_wd_rst;
  wire e_wake    = free & sleepy & ~e_stk_rst &
                   (evt.wdog_timeout | evt.irq_wake);
  wire e_wd_wk   = e_wake & evt.wdog_timeout;
  wire e_irq_wk  = e_wake & ~evt.wdog_timeout;
  wire e_rst     = e_pin | e_stk_rst | e_wd_rst | e_rinst;
  wire e_slp_wk  = e_wake & (pm_mode == PM_SLEEP);
  wire e_idl_wk  = e_wake & (pm_mode != PM_SLEEP);
  wire irq_vec   = e_irq_wk & (evt.high_priority_irq_enable |
                               evt.low_priority_irq_enable);
  wire [15:0] wake_vec = evt.irq_is_high ? `RTC_VEC_HIGH :
                                           `RTC_VEC_LOW;

  // ******************************************************************
  // timers
  // ******************************************************************
  wire slow_tick = (div_q == 12'(SLOW_DIV_CYC - 1));
  wire put_done  = (st_q == ST_PUT) & slow_tick &
                   (cnt_q == 17'(`RTC_PUT_TICKS - 1));
  wire xtal_done = (st_q == ST_XTAL) & osc_edge &
                   (cnt_q == 17'(`RTC_XTAL_EDGES - 1));
  wire pll_done  = (st_q == ST_PLL) &
                   (cnt_q == 17'(PLL_LOCK_CYC - 1));
  wire cnt_step  = ((st_q == ST_PUT) & slow_tick) |
                   ((st_q == ST_XTAL) & osc_edge) | (st_q == ST_PLL);
  wire go_run    = (st_q == ST_PIN) & pin_s & ~e_brown;

  // ******************************************************************
  // sequencer
  // ******************************************************************
  always_comb begin
    st_d     = st_q;
    power_d  = power_q;
    wake_d   = wake_q;
    vec_d    = vec_q;
    resume_d = resume_q;
    case (st_q)
      ST_BROWN: if (!(dip_on & brown_s)) st_d = ST_START;
      ST_START: st_d = put_use ? ST_PUT : after_put;
      ST_PUT:   if (put_done) st_d = after_put;
      ST_XTAL:  if (xtal_done) st_d = is_pll ? ST_PLL : ST_PIN;
      ST_PLL:   if (pll_done) st_d = ST_PIN;
      // timers ignore the pin; of the start-up states it is only checked here
      ST_PIN:   if (pin_s) st_d = ST_RUN;
      ST_RUN:   if (e_rst | e_slp_wk) st_d = ST_START;
      default:  st_d = ST_START;
    endcase
    if (go_run) begin
      power_d = 1'b0;
      wake_d  = 1'b0;
    end
    if (e_rst) begin
      power_d  = 1'b0;
      wake_d   = 1'b0;
      vec_d    = `RTC_VEC_RESET;
      resume_d = 1'b0;
    end
    if (e_slp_wk) begin
      wake_d   = 1'b1;
      vec_d    = wake_vec;
      resume_d = ~irq_vec;
    end
    if (e_brown) begin
      st_d     = ST_BROWN;
      power_d  = 1'b1;
      wake_d   = 1'b0;
      vec_d    = `RTC_VEC_RESET;
      resume_d = 1'b0;
    end
  end

  // ******************************************************************
  // apb decode
  // ******************************************************************
  wire setup    = psel & ~penable;
  wire acc      = psel & penable & pready_q;
  wire hit_ctrl = (paddr == `RTC_CTRL_OFS);
  wire hit_cs   = (paddr == `RTC_CAUSE_OFS);
  wire hit_stk  = (paddr == `RTC_STACK_OFS);
  wire hit_st   = (paddr == `RTC_STATE_OFS);
  wire bad      = ~(hit_ctrl | hit_cs | hit_stk | hit_st) |
                  (pwrite & hit_st);
  wire wr_ctrl  = acc & pwrite & hit_ctrl;
  wire wr_cause = acc & pwrite & hit_cs;
  wire wr_stk   = acc & pwrite & hit_stk;

  logic [31:0] cause_rd;
  logic [31:0] stk_rd;
  logic [31:0] st_rd;
  always_comb begin
    cause_rd = 32'h0;
    cause_rd[`RTC_CAUSE_SOFT_BIT]  = cause_q.soft_en & soft_cfg;
    cause_rd[`RTC_CAUSE_RINST_BIT] = cause_q.rinst;
    cause_rd[`RTC_CAUSE_TO_BIT]    = cause_q.to;
    cause_rd[`RTC_CAUSE_PDOWN_BIT] = cause_q.pdown;
    cause_rd[`RTC_CAUSE_POR_BIT]   = cause_q.por;
    cause_rd[`RTC_CAUSE_DIP_BIT]   = cause_q.dip;
    stk_rd = 32'h0;
    stk_rd[`RTC_STK_FULL_BIT] = stk_q[1];
    stk_rd[`RTC_STK_UNF_BIT]  = stk_q[0];
    st_rd = 32'h0;
    st_rd[2:0] = st_q;
    st_rd[`RTC_STATE_RUN_BIT] = core_run_q;
    st_rd[`RTC_STATE_RST_BIT] = core_reset_q;
  end

  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_q} :
                       hit_cs   ? cause_rd :
                       hit_stk  ? stk_rd :
                       hit_st   ? st_rd : 32'h0;

  // ******************************************************************
  // cause flags: software first, hardware wins over it
  // ******************************************************************
  always_comb begin
    cause_d = cause_q;
    stk_d   = stk_q;
    if (wr_cause) begin
      cause_d.soft_en = soft_cfg & pwdata[`RTC_CAUSE_SOFT_BIT];
      cause_d.rinst = pwdata[`RTC_CAUSE_RINST_BIT];
      cause_d.to    = pwdata[`RTC_CAUSE_TO_BIT];
      cause_d.pdown = pwdata[`RTC_CAUSE_PDOWN_BIT];
      cause_d.por   = pwdata[`RTC_CAUSE_POR_BIT];
      cause_d.dip   = pwdata[`RTC_CAUSE_DIP_BIT];
    end
    if (wr_stk) begin
      stk_d = {pwdata[`RTC_STK_FULL_BIT], pwdata[`RTC_STK_UNF_BIT]};
    end
    // a restart keeps the soft enable only in soft mode
    if ((e_rst | e_brown) & ~soft_cfg) begin
      cause_d.soft_en = 1'b0;
    end
    if (e_brown) begin
      cause_d.rinst = 1'b1;
      cause_d.to    = 1'b1;
      cause_d.pdown = 1'b1;
      cause_d.dip   = 1'b0;
    end
    if (e_pin & (pm_mode != PM_FULL)) begin
      cause_d.to = 1'b1;
    end
    if (e_pin & sleepy) begin
      cause_d.pdown = 1'b0;
    end
    if (e_wd_rst) begin
      cause_d.to = 1'b0;
    end
    if (e_wd_wk) begin
      cause_d.to    = 1'b0;
      cause_d.pdown = 1'b0;
    end
    if (e_irq_wk) begin
      cause_d.pdown = 1'b0;
    end
    if (e_rinst) begin
      cause_d.rinst = 1'b0;
    end
    if (e_full) begin
      stk_d[1] = 1'b1;
    end
    if (e_unf) begin
      stk_d[0] = 1'b1;
    end
  end

  // ******************************************************************
  // flops; power-on values only on reset_n, others keep
  // ******************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q  <= `RTC_CTRL_RST;
      cause_q <= `RTC_CAUSE_RST;
      stk_q   <= `RTC_STACK_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata[7:0];
      cause_q <= cause_d;
      stk_q   <= stk_d;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= ST_START;
      power_q  <= 1'b1;
      wake_q   <= 1'b0;
      resume_q <= 1'b0;
      vec_q    <= `RTC_VEC_RESET;
      cnt_q    <= 17'h00000;
      div_q    <= 12'h000;
    end else begin
      st_q     <= st_d;
      power_q  <= power_d;
      wake_q   <= wake_d;
      resume_q <= resume_d;
      vec_q    <= vec_d;
      cnt_q    <= (st_d != st_q) ? 17'h00000 :
                  cnt_step ? cnt_q + 17'h00001 : cnt_q;
      div_q    <= (slow_tick | (st_q == ST_START)) ? 12'h000 :
                  div_q + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reset_q <= 1'b1;
      core_run_q   <= 1'b0;
      pc_load_q    <= 1'b0;
      pc_resume_q  <= 1'b0;
      pc_value_q   <= `RTC_VEC_RESET;
    end else begin
      // a sleep wake stalls the core but does not reset it
      core_reset_q <= (st_d != ST_RUN) & ~wake_d;
      core_run_q   <= (st_d == ST_RUN);
      pc_load_q    <= (go_run & ~resume_q) | (e_idl_wk & irq_vec);
      pc_resume_q  <= (go_run & resume_q) | (e_idl_wk & ~irq_vec);
      pc_value_q   <= go_run ? vec_q : wake_vec;
    end
  end

  // zero wait state: answer in the first access cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & bad;
      if (setup) prdata_q <= pwrite ? 32'h0 : rd_mux;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign core_reset = core_reset_q;
  assign core_run   = core_run_q;
  assign pc_load    = pc_load_q;
  assign pc_resume  = pc_resume_q;
  assign pc_value   = pc_value_q;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_xtal_full_count:
    assert property ((st_q == ST_XTAL) && (st_d != ST_XTAL) && !e_brown
      |-> osc_edge && (cnt_q == 17'(`RTC_XTAL_EDGES - 1)))
    else $error("crystal timer left early");
  a_xtal_mode_only:
    assert property ((st_q == ST_XTAL) |-> is_xtal && need_dly)
    else $error("crystal timer in wrong mode");
  a_lock_after_xtal:
    assert property ((st_q == ST_XTAL) && xtal_done && is_pll && !e_brown
      |=> (st_q == ST_PLL) ##1 (st_q == ST_PLL))
    else $error("lock wait missing after crystal timer");
  a_put_then_xtal:
    assert property ((st_q == ST_PUT) && put_done && is_xtal
      && !e_brown |=> (st_q == ST_XTAL))
    else $error("crystal timer not after power-up timer");
  a_rcosc_no_delay:
    assert property ((st_q == ST_START) && ctrl_q.put_dis_n
      && (mode == RESISTOR_CAP_OSC_MODE) && !e_brown
      |=> (st_q == ST_PIN))
    else $error("rc mode applied a delay");
  a_put_power:
    assert property ((st_q == ST_PUT) |-> power_q
      && !ctrl_q.put_dis_n)
    else $error("power-up timer outside power-up");
  a_pin_release:
    assert property ((st_q == ST_PIN) && !pin_s && !wake_q
      |=> !core_run_q && core_reset_q)
    else $error("released with pin low");
  a_pin_go:
    assert property (go_run && !wake_q |=> core_run_q && pc_load_q
      && (pc_value_q == `RTC_VEC_RESET))
    else $error("no start when pin rose");
  a_wake_no_reset:
    assert property (e_slp_wk |=> !core_reset_q && !core_run_q)
    else $error("sleep wake reset the core");
  a_por_sw_only:
    assert property ($rose(cause_q.por)
      |-> $past(wr_cause && pwdata[`RTC_CAUSE_POR_BIT]))
    else $error("power-on flag set by hardware");
  a_wdog_clear_to:
    assert property (e_wd_rst |=> !cause_q.to && core_reset_q
      ##1 (st_q != ST_RUN))
    else $error("watchdog reset wrong");
  a_brown_restart:
    assert property (e_brown |=> (st_q == ST_BROWN) && core_reset_q
      && power_q && cause_q.rinst && !cause_q.dip)
    else $error("supply dip did not restart");
  a_unf_no_reset:
    assert property (e_unf && !ctrl_q.stk_rst_en && !evt.stack_full
      && !evt.wdog_timeout && !evt.reset_instr && !evt.irq_wake
      |=> stk_q[0] && core_run_q)
    else $error("underflow handling wrong");

  c_pll_path:   cover property ((st_q == ST_PLL) ##1 pll_done);
  c_idle_wake:  cover property (e_idl_wk ##1 pc_resume_q);
  c_brown:      cover property (e_brown ##1 (st_q == ST_BROWN));
  c_pin_hold:   cover property ((st_q == ST_PIN) && !pin_s);

endmodule

// File: tb_top.sv
/*
  tb_top: self-checking bench for rtc_top, start-up delays and cause flags.
  Assumes rtc_pkg is compiled first; the bench drives apb and all pins.
*/
`timescale 1ns/10ps

module tb_top
  import rtc_pkg::*;
;
  // ******************************************************************
  // signals
  // ******************************************************************
  localparam int SLOW = 2;
  localparam int LOCK = 8;
  logic        ref_clk, reset_n, psel, penable, pwrite, err, seen, rst;
  logic        pready, pslverr, core_reset, core_run, pc_load, pc_resume;
  logic        external_reset_n_pin, osc_input_pin, brownout_det;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] pc_value;
  logic [1:0]  osc_q;
  rtc_pm_t     pm_mode;
  rtc_evt_t    evt;
  int          n_fail, num_checks, cyc, t;

  rtc_top #(.SLOW_DIV_CYC(SLOW), .PLL_LOCK_CYC(LOCK)) u_dut (.ref_clk,
    .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .external_reset_n_pin, .osc_input_pin, .brownout_det,
    .pm_mode, .evt, .core_reset, .core_run, .pc_load, .pc_resume,
    .pc_value);

  // oscillator period of four clocks, slow enough for the pin sync
  assign osc_input_pin = osc_q[1];
  always @(posedge ref_clk) osc_q <= reset_n ? osc_q + 2'h1 : 2'h0;

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ******************************************************************
  // shared tasks
  // ******************************************************************
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask

  task automatic pulse(input logic [7:0] e);
    evt <= rtc_evt_t'(e);
    @(posedge ref_clk);
    evt <= '0;
  endtask

  // bounded wait; t holds the cycles spent
  task automatic wait_run;
    t = 0;
    while (core_run !== 1'b1 && t < 12000) begin
      @(posedge ref_clk);
      t++;
    end
  endtask

  task automatic pin_reset(input rtc_pm_t pm, input logic [31:0] e);
    pm_mode <= pm;
    external_reset_n_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("core_reset on pin", 32'h1, core_reset);
    pm_mode <= PM_FULL;
    external_reset_n_pin <= 1'b1;
    @(posedge ref_clk);
    wait_run;
    rd(8'h04, e, "cause after pin");
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_n, brownout_det} = '0;
    external_reset_n_pin = 1'b1;
    evt = '0;
    pm_mode = PM_FULL;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_run;
    // timer then 1024 oscillator periods of four clocks
    chk("powerup cycles", 32'h1, 32'(t >= 2048 * SLOW + 4096));
    chk("no early slack", 32'h1, 32'(t <= 2048 * SLOW + 4140));
    rd(8'h04, 32'h1C, "cause at power-on");
    rd(8'h00, 32'h00, "ctrl at power-on");
    apb(1'b1, 8'h00, 32'h1C);
    pulse(8'h10);
    #1;
    chk("reset instr", 32'h1, core_reset);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("run without delay", 32'h1, core_run);
    chk("pc_load", 32'h1, pc_load);
    chk("pc_value", 32'h0, pc_value);
    @(posedge ref_clk);
    rd(8'h04, 32'h0C, "cause after instr");
    pulse(8'h80);
    @(posedge ref_clk);
    wait_run;
    rd(8'h04, 32'h04, "cause after wdt");
    pin_reset(PM_FULL, 32'h04);
    pin_reset(PM_SLEEP, 32'h08);
    pm_mode <= PM_IDLE;
    @(posedge ref_clk);
    pulse(8'h80);
    {seen, rst} = 2'b00;
    repeat (4) begin
      @(posedge ref_clk);
      seen |= pc_resume;
      rst |= core_reset;
    end
    chk("idle wake resume", 32'h1, seen);
    chk("idle wake no reset", 32'h0, rst);
    pm_mode <= PM_FULL;
    rd(8'h04, 32'h00, "cause after wake");
    pulse(8'h20);
    repeat (3) @(posedge ref_clk);
    chk("run kept", 32'h1, core_run);
    rd(8'h08, 32'h40, "stack flags");
    apb(1'b1, 8'h00, 32'h9C);
    pulse(8'h40);
    @(posedge ref_clk);
    chk("stack reset", 32'h1, core_reset);
    wait_run;
    rd(8'h08, 32'hC0, "stack flags");
    apb(1'b1, 8'h04, 32'h02);
    apb(1'b1, 8'h00, 32'hFC);
    brownout_det <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("held in dip", 32'h1, core_reset);
    brownout_det <= 1'b0;
    @(posedge ref_clk);
    wait_run;
    rd(8'h04, 32'h1E, "cause after dip");
    apb(1'b1, 8'h00, 32'hF2);
    pm_mode <= PM_SLEEP;
    @(posedge ref_clk);
    pulse(8'h80);
    #1;
    chk("wake keeps core", 32'h0, {30'h0, core_reset, core_run});
    wait_run;
    chk("wake resume", 32'h1, {31'h0, pc_resume});
    chk("wake delay", 32'h1, 32'(t >= 4093 + LOCK));
    chk("wake slack", 32'h1, 32'(t <= 4140 + LOCK));
    pm_mode <= PM_FULL;
    rd(8'h04, 32'h12, "cause after sleep wake");
    rd(8'h10, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, err);
    apb(1'b1, 8'h0C, 32'hFF);
    chk("read-only error", 32'h1, err);
    end_sim;
  end

  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_sim;
    end
  end
endmodule
